// >>> logic/ext_irq_detect.sv
`timescale 1ns/10ps
`default_nettype none
module ext_irq_detect
   import pa_mux_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic clkEn,
   input  wire logic clear,
   pa_irq_if.det     irq
);

   typedef struct packed {
      logic prevLevel;
      logic edgeFlag;
   } det_t;

   det_t st_r;
   det_t st_nxt;

   // Active-low input: a falling edge or a low level requests.
   always_comb begin
      st_nxt = st_r;
      st_nxt.prevLevel = irq.pinLevel;
      if (clear) begin
         st_nxt.edgeFlag = 1'b0;
      end
      if (irq.enable && irq.edgeMode && st_r.prevLevel && !irq.pinLevel) begin
         st_nxt.edgeFlag = 1'b1;
      end
      if (!irq.enable) begin
         st_nxt.edgeFlag = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '{prevLevel: 1'b1, edgeFlag: 1'b0};
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   assign irq.request = irq.enable &&
                        (irq.edgeMode ? st_r.edgeFlag : !st_r.prevLevel);

endmodule
`default_nettype wire

// >>> logic/pa_irq_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pa_irq_if;
   logic pinLevel;
   logic enable;
   logic edgeMode;
   logic request;
   modport src (output pinLevel, output enable, output edgeMode, input request);
   modport det (input pinLevel, input enable, input edgeMode, output request);
endinterface
`default_nettype wire

// >>> logic/pa_mux_pkg.sv
package pa_mux_pkg;

   localparam int PORT_W = 8;

   // Register offsets on the plain register port.
   localparam logic [3:0] OFF_PORT_OUT   = 4'h0;
   localparam logic [3:0] OFF_PORT_OE    = 4'h1;
   localparam logic [3:0] OFF_PORT_PIN   = 4'h2;
   localparam logic [3:0] OFF_ALT_CFG    = 4'h3;
   localparam logic [3:0] OFF_IFC_CFG    = 4'h4;
   localparam logic [3:0] OFF_FIFO_POL   = 4'h5;
   localparam logic [3:0] OFF_RESUME_CTL = 4'h6;
   localparam logic [3:0] OFF_PROC_CTL   = 4'h7;
   localparam logic [3:0] OFF_TRIG_TYPE  = 4'h8;
   localparam logic [3:0] OFF_STATUS     = 4'h9;

   // Field positions.
   localparam int PROC_CLOCK_OUTPUT_PIN_HIZ = 1;
   localparam int PROC_CLK_SPD_LO = 3;
   localparam int FIFO_POL_OE     = 4;
   localparam int FIFO_POL_COMMIT = 5;
   localparam int RESUME_EN       = 1;
   localparam int RESUME_POL      = 4;
   localparam int TRIG_ZERO       = 0;
   localparam int TRIG_ONE        = 1;

   // Reset values and the slave interface code.
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [1:0] RST_IFC      = 2'h0;
   localparam logic [1:0] IFC_SLAVE    = 2'h3;

   // Clock speed codes for the 48 MHz phase-locked source.
   localparam logic [1:0] SPD_12 = 2'h0;
   localparam logic [1:0] SPD_24 = 2'h1;
   localparam logic [1:0] SPD_48 = 2'h2;

   typedef enum logic [1:0] {
      PWR_RUN     = 2'b00,
      PWR_SUSPEND = 2'b01,
      PWR_WAKE    = 2'b11
   } pwr_t;

endpackage

// >>> logic/port_a_pin_function_select.sv
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module port_a_pin_function_select
   import pa_mux_pkg::*;
#(
   parameter int PW = PORT_W
) (
   input  wire logic          clk_sys,
   input  wire logic          rst_b,
   input  wire logic          clkEn,
   input  wire logic          clk48,
   input  wire logic [3:0]    regAddr,
   input  wire logic [7:0]    regWrData,
   input  wire logic          regWr,
   input  wire logic          regRd,
   output logic      [7:0]    regRdData,
   input  wire logic [PW-1:0] portAIn,
   output logic      [PW-1:0] portAOut,
   output logic      [PW-1:0] portAOe,
   input  wire logic          codeSourceSelect,
   input  wire logic [15:0]   fetchAddr,
   input  wire logic          fetchReq,
   output logic              fetchInternal,
   output logic              fetchExternal,
   input  wire logic          suspendReq,
   output logic              suspended,
   output logic              oscRestart,
   output logic              resumeIrq,
   output logic              extIrqZeroReq,
   output logic              extIrqOneReq,
   output logic              fifoReadOutputEnable,
   output logic      [1:0]    fifoSelect,
   output logic              packetCommitPulse,
   output logic              clockOutputPin,
   output logic              clockOutputOe,
   output logic      [1:0]    cpuClockSpeed
);

   localparam logic [15:0] LOW_CODE_TOP = 16'h3FFF;

   typedef struct packed {
      logic [7:0]    portOut;
      logic [7:0]    portOe;
      logic [7:0]    altCfg;
      logic [1:0]    ifcCfg;
      logic [7:0]    fifoPol;
      logic [7:0]    resumeCtl;
      logic [7:0]    procCtl;
      logic [7:0]    trigType;
      logic [7:0]    rdData;
      logic [7:0]    pinSample;
      pwr_t          pwr;
      logic          resumeAct;
      logic          commitPrev;
      logic          commitPulse;
      logic          oscRestart;
      logic          resumeIrq;
      logic          fetchInt;
      logic          fetchExt;
      logic          slaveOe;
      logic [1:0]    fifoSel;
      logic          irqZero;
      logic          irqOne;
      logic          clkOe;
      logic          clkPhase;
      logic [1:0]    clkDiv;
      logic [7:0]    padOut;
      logic [7:0]    padOe;
      logic [1:0]    irqClr;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   pa_irq_if irqZeroIf ();
   pa_irq_if irqOneIf ();

   logic slaveMode;
   assign slaveMode = (st_r.ifcCfg == IFC_SLAVE);

   assign irqZeroIf.pinLevel = st_r.pinSample[0];
   assign irqZeroIf.enable   = st_r.altCfg[0];
   assign irqZeroIf.edgeMode = st_r.trigType[TRIG_ZERO];
   assign irqOneIf.pinLevel  = st_r.pinSample[1];
   assign irqOneIf.enable    = st_r.altCfg[1];
   assign irqOneIf.edgeMode  = st_r.trigType[TRIG_ONE];

   ext_irq_detect u_irq_zero (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clkEn   (clkEn),
      .clear   (st_r.irqClr[0]),
      .irq     (irqZeroIf.det)
   );

   ext_irq_detect u_irq_one (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .clkEn   (clkEn),
      .clear   (st_r.irqClr[1]),
      .irq     (irqOneIf.det)
   );

   always_comb begin
      logic [7:0] altMask;
      logic       resumeLvl;
      logic       commitLvl;
      logic [1:0] spd;
      st_nxt = st_r;
      altMask = 8'h00;
      resumeLvl = 1'b0;
      commitLvl = 1'b0;
      spd = SPD_12;
      st_nxt.pinSample = portAIn;
      st_nxt.irqClr = 2'h0;
      st_nxt.rdData = 8'h00;

      // Register writes.
      if (regWr) begin
         unique case (regAddr)
            OFF_PORT_OUT:   st_nxt.portOut = regWrData;
            OFF_PORT_OE:    st_nxt.portOe = regWrData;
            OFF_ALT_CFG:    st_nxt.altCfg = regWrData;
            OFF_IFC_CFG:    st_nxt.ifcCfg = regWrData[1:0];
            OFF_FIFO_POL:   st_nxt.fifoPol = regWrData;
            OFF_RESUME_CTL: st_nxt.resumeCtl = regWrData;
            OFF_PROC_CTL:   st_nxt.procCtl = regWrData;
            OFF_TRIG_TYPE:  st_nxt.trigType = regWrData;
            OFF_STATUS:     st_nxt.irqClr = regWrData[1:0];
            default:        st_nxt.portOut = st_r.portOut;
         endcase
      end

      // Read data stands one cycle after the strobe; unmapped reads return zero.
      if (regRd) begin
         unique case (regAddr)
            OFF_PORT_OUT:   st_nxt.rdData = st_r.portOut;
            OFF_PORT_OE:    st_nxt.rdData = st_r.portOe;
            OFF_PORT_PIN:   st_nxt.rdData = st_r.pinSample;
            OFF_ALT_CFG:    st_nxt.rdData = st_r.altCfg;
            OFF_IFC_CFG:    st_nxt.rdData = {6'h00, st_r.ifcCfg};
            OFF_FIFO_POL:   st_nxt.rdData = st_r.fifoPol;
            OFF_RESUME_CTL: st_nxt.rdData = st_r.resumeCtl;
            OFF_PROC_CTL:   st_nxt.rdData = st_r.procCtl;
            OFF_TRIG_TYPE:  st_nxt.rdData = st_r.trigType;
            OFF_STATUS:     st_nxt.rdData = {3'h0, st_r.pwr == PWR_SUSPEND,
                                             st_r.resumeAct, 1'b0,
                                             irqOneIf.request, irqZeroIf.request};
            default:        st_nxt.rdData = 8'h00;
         endcase
      end

      // Code fetch steering for the low program space.
      st_nxt.fetchInt = fetchReq && (fetchAddr <= LOW_CODE_TOP) && !codeSourceSelect;
      st_nxt.fetchExt = fetchReq && ((fetchAddr > LOW_CODE_TOP) || codeSourceSelect);

      // Alternate functions of pins 0, 1, 2 and 4 to 6.
      altMask[0] = st_r.altCfg[0];
      altMask[1] = st_r.altCfg[1];
      if (slaveMode) begin
         altMask[2] = 1'b1;
         altMask[4] = 1'b1;
         altMask[5] = 1'b1;
         altMask[6] = 1'b1;
      end
      st_nxt.irqZero = irqZeroIf.request;
      st_nxt.irqOne  = irqOneIf.request;
      // Alternate pins are forced to input so the external master never fights us.
      st_nxt.padOut = st_r.portOut & ~altMask;
      st_nxt.padOe  = st_r.portOe & ~altMask;

      st_nxt.slaveOe = slaveMode && (st_r.pinSample[2] == st_r.fifoPol[FIFO_POL_OE]);
      st_nxt.fifoSel = slaveMode ? st_r.pinSample[5:4] : 2'h0;
      commitLvl = slaveMode && (st_r.pinSample[6] == st_r.fifoPol[FIFO_POL_COMMIT]);
      st_nxt.commitPrev = commitLvl;
      st_nxt.commitPulse = commitLvl && !st_r.commitPrev;

      // Alternate resume source on bit 3.
      resumeLvl = st_r.resumeCtl[RESUME_EN] &&
                  (st_r.pinSample[3] == st_r.resumeCtl[RESUME_POL]);
      st_nxt.resumeAct = resumeLvl;
      st_nxt.oscRestart = 1'b0;
      st_nxt.resumeIrq = 1'b0;
      unique case (st_r.pwr)
         PWR_RUN: begin
            if (suspendReq && !resumeLvl) begin
               st_nxt.pwr = PWR_SUSPEND;
            end
         end
         PWR_SUSPEND: begin
            // Any transition wakes, so a pin that changes while entering is not missed.
            if (st_r.resumeCtl[RESUME_EN] && (resumeLvl != st_r.resumeAct)) begin
               st_nxt.pwr = PWR_WAKE;
               st_nxt.oscRestart = 1'b1;
               st_nxt.resumeIrq = 1'b1;
            end
         end
         PWR_WAKE: st_nxt.pwr = PWR_RUN;
         default:  st_nxt.pwr = PWR_RUN;
      endcase

      // Clock output: clk48 at SPD_48, otherwise clk_sys divided by 2 at SPD_24 or by 4.
      spd = st_r.procCtl[PROC_CLK_SPD_LO +: 2];
      st_nxt.clkOe = !st_r.procCtl[PROC_CLOCK_OUTPUT_PIN_HIZ];
      st_nxt.clkDiv = st_r.clkDiv + 2'h1;
      unique case (spd)
         SPD_48:  st_nxt.clkPhase = clk48;
         SPD_24:  st_nxt.clkPhase = st_r.clkDiv[0];
         default: st_nxt.clkPhase = st_r.clkDiv[1];
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.pinSample <= 8'hFF;
         st_r.commitPrev <= 1'b0;
         st_r.pwr <= PWR_RUN;
         st_r.resumeAct <= 1'b0;
         st_r.clkOe <= 1'b1;
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   assign regRdData            = st_r.rdData;
   assign portAOut             = st_r.padOut[PW-1:0];
   assign portAOe              = st_r.padOe[PW-1:0];
   assign fetchInternal        = st_r.fetchInt;
   assign fetchExternal        = st_r.fetchExt;
   assign suspended            = (st_r.pwr == PWR_SUSPEND);
   assign oscRestart           = st_r.oscRestart;
   assign resumeIrq            = st_r.resumeIrq;
   assign extIrqZeroReq        = st_r.irqZero;
   assign extIrqOneReq         = st_r.irqOne;
   assign fifoReadOutputEnable = st_r.slaveOe;
   assign fifoSelect           = st_r.fifoSel;
   assign packetCommitPulse    = st_r.commitPulse;
   assign clockOutputPin       = st_r.clkPhase;
   assign clockOutputOe        = st_r.clkOe;
   assign cpuClockSpeed        = st_r.procCtl[PROC_CLK_SPD_LO +: 2];

endmodule
`default_nettype wire

// >>> verif/fifo_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module fifo_master_model (
   input  wire logic       clk_sys,
   input  wire logic       go,
   input  wire logic [1:0] sel,
   input  wire logic       oeOn,
   input  wire logic       comOn,
   output logic      [3:0] pins
);
   logic [1:0] step_r = 2'h0;
   always_ff @(posedge clk_sys) begin
      step_r <= go ? 2'h1 : step_r + {1'h0, step_r != 2'h0};
   end
   // Idle select lines show the inverted code, so a stale value is never mistaken for a new one.
   always_comb begin
      pins[2:1] = (step_r == 2'h0) ? ~sel : sel;
      pins[0] = (step_r == 2'h1 || step_r == 2'h2) ? oeOn : ~oeOn;
      pins[3] = (step_r == 2'h2) ? comOn : ~comOn;
   end
endmodule
`default_nettype wire

// >>> verif/pa_fn_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module pa_fn_monitor
   import pa_mux_pkg::*;
#(
   parameter int PW = PORT_W
) (
   input wire logic          clk_sys,
   input wire logic          rst_b,
   input wire logic [3:0]    regAddr,
   input wire logic [7:0]    regWrData,
   input wire logic          regWr,
   input wire logic [PW-1:0] portAIn,
   input wire logic [PW-1:0] portAOe,
   input wire logic          codeSourceSelect,
   input wire logic [15:0]   fetchAddr,
   input wire logic          fetchReq,
   input wire logic          fetchInternal,
   input wire logic          fetchExternal,
   input wire logic          suspended,
   input wire logic          oscRestart,
   input wire logic          resumeIrq,
   input wire logic          fifoReadOutputEnable,
   input wire logic [1:0]    fifoSelect,
   input wire logic          packetCommitPulse,
   input wire logic          clockOutputOe,
   input wire logic [1:0]    cpuClockSpeed
);
   logic [1:0] ifcM_r;
   logic [7:0] polM_r;
   logic [1:0] up_r;
   logic       slaveM;
   assign slaveM = (ifcM_r == IFC_SLAVE);
   // Shadow copies let pin relations be judged without seeing the register file.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ifcM_r <= RST_IFC;
         polM_r <= RST_BYTE;
         up_r <= 2'h0;
      end else begin
         if (regWr && regAddr == OFF_IFC_CFG) begin
            ifcM_r <= regWrData[1:0];
         end
         if (regWr && regAddr == OFF_FIFO_POL) begin
            polM_r <= regWrData;
         end
         if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
         end
      end
   end
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence pulseEnd;
      !oscRestart && !resumeIrq;
   endsequence
   a_reset_defaults: assert property ($rose(rst_b) |-> portAOe == '0 && cpuClockSpeed == SPD_12 && clockOutputOe)
      else $error("reset defaults wrong");
   a_fetch_int: assert property (fetchReq && !codeSourceSelect && fetchAddr <= 16'h3FFF |=> fetchInternal && !fetchExternal)
      else $error("fetch not internal");
   a_fetch_ext: assert property (fetchReq && (codeSourceSelect || fetchAddr > 16'h3FFF) |=> fetchExternal && !fetchInternal)
      else $error("fetch not external");
   a_clock_output_pin_float: assert property (regWr && regAddr == OFF_PROC_CTL |-> ##2 clockOutputOe == !$past(regWrData[PROC_CLOCK_OUTPUT_PIN_HIZ], 2))
      else $error("clock output enable wrong");
   a_speed_select: assert property (regWr && regAddr == OFF_PROC_CTL |-> ##2 cpuClockSpeed == $past(regWrData[4:3], 2))
      else $error("clock speed wrong");
   a_fifo_select: assert property (up_r == 2'h3 |-> fifoSelect == ($past(slaveM) ? $past(portAIn[5:4], 2) : 2'h0))
      else $error("fifo select wrong");
   a_oe_polarity: assert property (up_r == 2'h3 |-> fifoReadOutputEnable == ($past(slaveM) && $past(portAIn[2], 2) == $past(polM_r[FIFO_POL_OE])))
      else $error("fifo output enable wrong");
   a_commit_once: assert property (packetCommitPulse |-> ($past(slaveM) && $past(portAIn[6], 2) == $past(polM_r[FIFO_POL_COMMIT])) ##1 !packetCommitPulse)
      else $error("commit pulse wrong");
   a_alt_no_drive: assert property ($past(slaveM) |-> portAOe[6:4] == 3'h0 && !portAOe[2])
      else $error("alternate pin driven");
   a_wake_pulse: assert property (oscRestart |-> resumeIrq ##1 pulseEnd ##[0:2] !suspended)
      else $error("wake sequence wrong");
endmodule
bind port_a_pin_function_select pa_fn_monitor #(.PW(PW)) mon (.clk_sys, .rst_b, .regAddr, .regWrData,
   .regWr, .portAIn, .portAOe, .codeSourceSelect, .fetchAddr, .fetchReq, .fetchInternal,
   .fetchExternal, .suspended, .oscRestart, .resumeIrq, .fifoReadOutputEnable, .fifoSelect,
   .packetCommitPulse, .clockOutputOe, .cpuClockSpeed);
`default_nettype wire

// >>> verif/port_a_pin_function_select_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module port_a_pin_function_select_tb_top;
   import pa_mux_pkg::*;
   logic        clk_sys, rst_b, clkEn, clk48, regWr, regRd, codeSourceSelect, fetchReq, go;
   logic        suspendReq, fetchInternal, fetchExternal, suspended, oscRestart, resumeIrq;
   logic        extIrqZeroReq, extIrqOneReq, fifoReadOutputEnable, packetCommitPulse, irqQ;
   logic        clockOutputPin, clockOutputOe, oeOn, comOn;
   logic [1:0]  fifoSelect, cpuClockSpeed, sel;
   logic [3:0]  regAddr, mPins;
   logic [7:0]  regWrData, regRdData, portAIn, portAOut, portAOe, pinDrv, rdv;
   logic [15:0] fetchAddr;
   int          errTotal, compares, seed, n, k, e, regM[16], expQ[$];
   assign portAIn = {pinDrv[7], mPins[3:1], pinDrv[3], mPins[0], pinDrv[1:0]};
   assign irqQ = n[0] ? extIrqOneReq : extIrqZeroReq;
   port_a_pin_function_select DUT (.clk_sys, .rst_b, .clkEn, .clk48, .regAddr, .regWrData, .regWr,
      .regRd, .regRdData, .portAIn, .portAOut, .portAOe, .codeSourceSelect, .fetchAddr, .fetchReq,
      .fetchInternal, .fetchExternal, .suspendReq, .suspended, .oscRestart, .resumeIrq,
      .extIrqZeroReq, .extIrqOneReq, .fifoReadOutputEnable, .fifoSelect, .packetCommitPulse,
      .clockOutputPin, .clockOutputOe, .cpuClockSpeed);
   fifo_master_model PM (.clk_sys, .go, .sel, .oeOn, .comOn, .pins(mPins));
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      clk48 = 1'h0;
      forever #10.41 clk48 = ~clk48;
   end
   task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      compares++;
      if (got !== ex) begin
         errTotal++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task stopTest;
      $display("Comparisons %0d mismatches %0d", compares, errTotal);
      if (errTotal == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task look(input int c);
      repeat (c) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'h1;
      @(posedge clk_sys);
      regWr <= 1'h0;
      regM[a] = d;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRd <= 1'h1;
      @(posedge clk_sys);
      regRd <= 1'h0;
      @(negedge clk_sys);
      rdv = regRdData;
   endtask
   task setPins(input logic [7:0] v);
      @(posedge clk_sys);
      pinDrv <= v;
      look(2);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      errTotal++;
      stopTest;
   end
   initial begin
      seed = 51500;
      {regWr, regRd, codeSourceSelect, fetchReq, suspendReq, go, oeOn, comOn} = 8'h00;
      {rst_b, clkEn, regAddr, regWrData, fetchAddr, sel, pinDrv} = {2'h1, 30'h0, 8'hFF};
      rst_b = 1'h0;
      repeat (12) @(posedge clk_sys);
      rst_b <= 1'h1;
      look(0);
      chk("clkoe", 1, clockOutputOe);
      for (n = 0; n < 16; n++) begin
         if (n != 2) begin
            rd(n[3:0]);
            chk("reg", 8'h00, rdv);
         end
      end
      wr(OFF_PORT_OUT, $random(seed));
      wr(OFF_PORT_OE, $random(seed));
      look(1);
      chk("out", regM[0], portAOut);
      chk("oe", regM[1], portAOe);
      $display("Test reset and port done");
      repeat (16) begin
         @(posedge clk_sys);
         fetchReq <= 1'h1;
         fetchAddr <= $random(seed);
         codeSourceSelect <= $random(seed);
         look(1);
         e = !codeSourceSelect && fetchAddr <= 16'h3FFF;
         chk("fint", e, fetchInternal);
         chk("fext", !e, fetchExternal);
      end
      @(posedge clk_sys);
      fetchReq <= 1'h0;
      for (n = 0; n < 6; n++) begin
         wr(OFF_PROC_CTL, ((n >> 1) << 3) | ((n & 1) << 1));
         look(1);
         chk("spd", n >> 1, cpuClockSpeed);
         chk("hiz", !(n & 1), clockOutputOe);
      end
      $display("Test fetch and clock done");
      wr(OFF_ALT_CFG, 8'h03);
      for (n = 0; n < 4; n++) begin
         wr(OFF_TRIG_TYPE, n[1] ? 8'h01 << n[0] : 8'h00);
         // The request leaves the pin sample, the detector and the output stage: three edges.
         setPins(8'hFF ^ (8'h01 << n[0]));
         look(1);
         chk("irqset", 1, irqQ);
         setPins(8'hFF);
         look(1);
         chk("irqhold", n[1], irqQ);
         wr(OFF_STATUS, 8'h03);
         look(2);
         chk("irqclr", 0, irqQ);
      end
      wr(OFF_ALT_CFG, 8'h00);
      $display("Test interrupt done");
      for (n = 0; n < 8; n++) begin
         wr(OFF_IFC_CFG, n[2] ? IFC_SLAVE : RST_IFC);
         wr(OFF_FIFO_POL, {2'h0, n[1:0], 4'h0});
         @(posedge clk_sys);
         {sel, oeOn, comOn, go} <= {n[1:0], n[0], n[1], 1'h1};
         @(posedge clk_sys);
         go <= 1'h0;
         expQ.push_back(n[2]);
         e = 0;
         for (k = 1; k <= 8; k++) begin
            @(negedge clk_sys);
            e += packetCommitPulse;
            if (k == 3) begin
               chk("fsel", n[2] ? n[1:0] : 0, fifoSelect);
               chk("foe", n[2], fifoReadOutputEnable);
               chk("altoe", n[2] ? 0 : regM[1] & 8'h74, portAOe & 8'h74);
            end
         end
         chk("commit", expQ.pop_front(), e);
      end
      wr(OFF_IFC_CFG, RST_IFC);
      $display("Test slave fifo done");
      wr(OFF_RESUME_CTL, 8'h12);
      @(posedge clk_sys);
      suspendReq <= 1'h1;
      look(3);
      chk("nosusp", 0, suspended);
      setPins(8'hF7);
      look(1);
      chk("susp", 1, suspended);
      @(posedge clk_sys);
      pinDrv <= 8'hFF;
      e = 0;
      for (k = 0; k < 10 && e == 0; k++) begin
         @(negedge clk_sys);
         e = oscRestart && resumeIrq;
      end
      chk("wake", 1, e);
      look(3);
      chk("run", 0, suspended);
      @(posedge clk_sys);
      suspendReq <= 1'h0;
      rst_b <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'h1;
      look(0);
      chk("rstspd", SPD_12, cpuClockSpeed);
      chk("rstoe", 8'h00, portAOe);
      $display("Test resume and reset done");
      stopTest;
   end
endmodule
`default_nettype wire
